// [rtl/mcr_pkg.sv]
// Constants for the monitor control, alert and fault register bank
package mcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_SECONDARY_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_ALERT_ENABLE      = 8'h02;
  localparam logic [7:0] ADDR_FAULT_LOG         = 8'h03;
  localparam logic [7:0] ADDR_RESOLUTION        = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the secondary control and resolution registers
  localparam int CTL_ALERT_CLEAR_BIT = 7;
  localparam int CTL_CLEAR_ON_READ_BIT = 5;
  localparam int CTL_AUTO_WAKE_BIT = 4;
  localparam int CTL_PEAK_RESET_BIT = 3;
  localparam int CTL_SOFT_RESET_BIT = 0;
  localparam int RES_EIGHT_BIT = 7;

  // Writable-bit masks; the rest read as zero
  localparam logic [7:0] CTL_WRITE_MASK = 8'hb9;
  localparam logic [7:0] RES_WRITE_MASK = 8'h80;

  // Reset values
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] ALERT_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [7:0] RES_RESET   = 8'h00;

  // Fault bit order: power max/min, shunt max/min, rail max/min, aux max/min
  localparam int FLT_POWER_HI = 7;
  localparam int FLT_POWER_LO = 6;
  localparam int FLT_SHUNT_HI = 5;
  localparam int FLT_SHUNT_LO = 4;
  localparam int FLT_RAIL_HI  = 3;
  localparam int FLT_RAIL_LO  = 2;
  localparam int FLT_AUX_HI   = 1;
  localparam int FLT_AUX_LO   = 0;

  // Measurement width of the compared values
  localparam int MEAS_W = 24;

endpackage

// [rtl/mcr_regs.sv]
// Control, alert-enable, fault-log and resolution register bank
`timescale 1ns/100ps
module mcr_regs (
  // Clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  // Register port from the bus engine
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // Bus events
  input  wire logic                      bus_addressed,
  input  wire logic                      stuck_bus_timeout,
  input  wire logic                      in_shutdown,
  // Channel-1 measurements and thresholds
  input  wire logic [mcr_pkg::MEAS_W-1:0] supply1_power_product,
  input  wire logic [mcr_pkg::MEAS_W-1:0] power_max,
  input  wire logic [mcr_pkg::MEAS_W-1:0] power_min,
  input  wire logic [mcr_pkg::MEAS_W-1:0] shunt1_differential_voltage,
  input  wire logic [mcr_pkg::MEAS_W-1:0] shunt_max,
  input  wire logic [mcr_pkg::MEAS_W-1:0] shunt_min,
  input  wire logic [mcr_pkg::MEAS_W-1:0] supply1_rail_voltage,
  input  wire logic [mcr_pkg::MEAS_W-1:0] rail_max,
  input  wire logic [mcr_pkg::MEAS_W-1:0] rail_min,
  input  wire logic [mcr_pkg::MEAS_W-1:0] aux_input_one,
  input  wire logic [mcr_pkg::MEAS_W-1:0] aux_max,
  input  wire logic [mcr_pkg::MEAS_W-1:0] aux_min,
  // Control outputs
  output logic                           alert_out,
  output logic                           wake_request,
  output logic                           peak_hold_reset,
  output logic                           soft_reset,
  output logic                           adc_eight_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] secondary_control;       // Writable control bits
  logic [7:0] channel1_alert_enable;   // Alert mask
  logic [7:0] channel1_fault_log;      // Sticky fault bits
  logic [7:0] adc_resolution_select;   // Resolution bit
  logic [7:0] next_secondary_control;
  logic [7:0] next_alert_enable;
  logic [7:0] next_fault_log;
  logic [7:0] next_resolution;
  logic [7:0] next_rdata;
  logic       next_alert;
  logic       next_wake;
  logic       next_peak;
  logic       next_soft;
  logic       next_eight_bit;          // Resolution output next value
  logic [7:0] fault_now;               // Present fault conditions

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fault condition comparators, strict inequalities
  always_comb begin
    fault_now = 8'h00;
    fault_now[mcr_pkg::FLT_POWER_HI] = supply1_power_product > power_max;
    fault_now[mcr_pkg::FLT_POWER_LO] = supply1_power_product < power_min;
    fault_now[mcr_pkg::FLT_SHUNT_HI] = shunt1_differential_voltage > shunt_max;
    fault_now[mcr_pkg::FLT_SHUNT_LO] = shunt1_differential_voltage < shunt_min;
    fault_now[mcr_pkg::FLT_RAIL_HI]  = supply1_rail_voltage > rail_max;
    fault_now[mcr_pkg::FLT_RAIL_LO]  = supply1_rail_voltage < rail_min;
    fault_now[mcr_pkg::FLT_AUX_HI]   = aux_input_one > aux_max;
    fault_now[mcr_pkg::FLT_AUX_LO]   = aux_input_one < aux_min;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next register values
  always_comb begin
    next_secondary_control = secondary_control;
    next_alert_enable      = channel1_alert_enable;
    next_fault_log         = channel1_fault_log;
    next_resolution        = adc_resolution_select;
    next_rdata             = reg_rdata;
    next_peak              = 1'b0;
    next_soft              = 1'b0;
    next_alert             = alert_out;
    next_wake              = 1'b0;
    // Read mux; unmapped offsets read as zero
    if (reg_rd) begin
      case (reg_addr)
        mcr_pkg::ADDR_SECONDARY_CONTROL: next_rdata = secondary_control;
        mcr_pkg::ADDR_ALERT_ENABLE:      next_rdata = channel1_alert_enable;
        mcr_pkg::ADDR_FAULT_LOG:         next_rdata = channel1_fault_log;
        mcr_pkg::ADDR_RESOLUTION:        next_rdata = adc_resolution_select;
        default:                         next_rdata = 8'h00;
      endcase
      // Clear-on-read of the fault log
      if (hit(reg_addr, mcr_pkg::ADDR_FAULT_LOG) &&
          secondary_control[mcr_pkg::CTL_CLEAR_ON_READ_BIT]) begin
        next_fault_log = 8'h00;
      end
    end
    // Register writes
    if (reg_wr) begin
      if (hit(reg_addr, mcr_pkg::ADDR_SECONDARY_CONTROL)) begin
        next_secondary_control = reg_wdata & mcr_pkg::CTL_WRITE_MASK;
        next_peak = reg_wdata[mcr_pkg::CTL_PEAK_RESET_BIT];
        next_soft = reg_wdata[mcr_pkg::CTL_SOFT_RESET_BIT];
      end
      if (hit(reg_addr, mcr_pkg::ADDR_ALERT_ENABLE)) begin
        next_alert_enable = reg_wdata;
      end
      if (hit(reg_addr, mcr_pkg::ADDR_FAULT_LOG)) begin
        next_fault_log = reg_wdata;
      end
      if (hit(reg_addr, mcr_pkg::ADDR_RESOLUTION)) begin
        next_resolution = reg_wdata & mcr_pkg::RES_WRITE_MASK;
      end
    end
    // New faults win over a host write or clear-on-read, not a soft reset; bits stay until cleared
    next_fault_log = next_fault_log | fault_now;
    // Alert: set by enabled faults, released on addressing when enabled
    if (bus_addressed && secondary_control[mcr_pkg::CTL_ALERT_CLEAR_BIT]) begin
      next_alert = 1'b0;
    end
    if ((fault_now & channel1_alert_enable) != 8'h00) begin
      next_alert = 1'b1;
    end
    // Wake from shutdown on stuck-bus timeout
    next_wake = stuck_bus_timeout && in_shutdown &&
                secondary_control[mcr_pkg::CTL_AUTO_WAKE_BIT];
    // Software reset returns control, mask, log, resolution and alert to defaults
    if (soft_reset) begin
      next_secondary_control = mcr_pkg::CTL_RESET;
      next_alert_enable      = mcr_pkg::ALERT_RESET;
      next_fault_log         = mcr_pkg::FAULT_RESET;
      next_resolution        = mcr_pkg::RES_RESET;
      next_alert             = 1'b0;
    end
    // Resolution output follows the stored select bit
    next_eight_bit = next_resolution[mcr_pkg::RES_EIGHT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      secondary_control     <= mcr_pkg::CTL_RESET;
      channel1_alert_enable <= mcr_pkg::ALERT_RESET;
      channel1_fault_log    <= mcr_pkg::FAULT_RESET;
      adc_resolution_select <= mcr_pkg::RES_RESET;
      reg_rdata             <= 8'h00;
      alert_out             <= 1'b0;
      wake_request          <= 1'b0;
      peak_hold_reset       <= 1'b0;
      soft_reset            <= 1'b0;
      adc_eight_bit         <= 1'b0;
    end else if (clk_en) begin
      secondary_control     <= next_secondary_control;
      channel1_alert_enable <= next_alert_enable;
      channel1_fault_log    <= next_fault_log;
      adc_resolution_select <= next_resolution;
      reg_rdata             <= next_rdata;
      alert_out             <= next_alert;
      wake_request          <= next_wake;
      peak_hold_reset       <= next_peak;
      soft_reset            <= next_soft;
      adc_eight_bit         <= next_eight_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Control write that sets bit b, outside a soft reset
  sequence s_ctl_write(int b);
    clk_en && reg_wr && reg_addr == mcr_pkg::ADDR_SECONDARY_CONTROL && reg_wdata[b]
      && !soft_reset;
  endsequence

  // Lone read of the fault log, outside a soft reset
  sequence s_fault_read;
    clk_en && reg_rd && !reg_wr && reg_addr == mcr_pkg::ADDR_FAULT_LOG && !soft_reset;
  endsequence

  // Lone write of one offset, outside a soft reset
  sequence s_reg_write(logic [7:0] off);
    clk_en && reg_wr && !reg_rd && reg_addr == off && !soft_reset;
  endsequence

  // Reserved bits never hold a one
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (secondary_control & ~mcr_pkg::CTL_WRITE_MASK) == 8'h00 &&
    (adc_resolution_select & ~mcr_pkg::RES_WRITE_MASK) == 8'h00)
    else $error("reserved bits not zero");

  // Addressing with the clear bit set drops the alert
  a_alert_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bus_addressed && secondary_control[mcr_pkg::CTL_ALERT_CLEAR_BIT]
    && (fault_now & channel1_alert_enable) == 8'h00 |=> !alert_out)
    else $error("alert not released on addressing");

  // Without the clear bit the alert stays up
  a_alert_kept: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && alert_out && !secondary_control[mcr_pkg::CTL_ALERT_CLEAR_BIT]
    && !soft_reset |=> alert_out)
    else $error("alert dropped while clear disabled");

  // Clear-on-read keeps only faults present during the read
  a_cor_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_fault_read ##0 secondary_control[mcr_pkg::CTL_CLEAR_ON_READ_BIT] |=>
    channel1_fault_log == $past(fault_now))
    else $error("fault log not cleared on read");

  // Reading with clear-on-read off leaves the log alone
  a_cor_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_fault_read ##0 !secondary_control[mcr_pkg::CTL_CLEAR_ON_READ_BIT] |=>
    channel1_fault_log == $past(channel1_fault_log | fault_now))
    else $error("fault log changed by plain read");

  // Wake request follows timeout, shutdown and enable
  a_auto_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> wake_request == $past(stuck_bus_timeout && in_shutdown &&
    secondary_control[mcr_pkg::CTL_AUTO_WAKE_BIT]))
    else $error("wake request mismatch");

  // Peak-hold write raises the pulse next cycle
  a_peak_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ctl_write(mcr_pkg::CTL_PEAK_RESET_BIT) |=> peak_hold_reset)
    else $error("peak hold reset not pulsed");

  // No peak-hold pulse without its write
  a_peak_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !(reg_wr && reg_addr == mcr_pkg::ADDR_SECONDARY_CONTROL &&
    reg_wdata[mcr_pkg::CTL_PEAK_RESET_BIT]) |=> !peak_hold_reset)
    else $error("peak hold reset without a write");

  // Soft reset pulse clears the registers a cycle later
  a_soft_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ctl_write(mcr_pkg::CTL_SOFT_RESET_BIT) ##1 (soft_reset && clk_en) |=>
    channel1_alert_enable == 8'h00 && secondary_control == 8'h00 && !alert_out)
    else $error("soft reset did not restore defaults");

  // No soft reset pulse without its write
  a_soft_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !(reg_wr && reg_addr == mcr_pkg::ADDR_SECONDARY_CONTROL &&
    reg_wdata[mcr_pkg::CTL_SOFT_RESET_BIT]) |=> !soft_reset)
    else $error("soft reset without a write");

  // Logged bits survive idle cycles
  a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !reg_wr && !reg_rd && !soft_reset |=>
    (channel1_fault_log & $past(channel1_fault_log | fault_now)) ==
    $past(channel1_fault_log | fault_now))
    else $error("fault bit lost");

  // Every present condition lands in the log
  a_fault_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !soft_reset |=> (channel1_fault_log & $past(fault_now)) == $past(fault_now))
    else $error("present fault not logged");

  // Host write replaces the log, new faults still win
  a_fault_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg_write(mcr_pkg::ADDR_FAULT_LOG) |=>
    channel1_fault_log == $past(reg_wdata | fault_now))
    else $error("fault log write lost");

  // Alert mask takes the written byte
  a_enable_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg_write(mcr_pkg::ADDR_ALERT_ENABLE) |=>
    channel1_alert_enable == $past(reg_wdata))
    else $error("alert enable write lost");

  // Read of the mask offset returns the mask
  a_rd_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && reg_rd && reg_addr == mcr_pkg::ADDR_ALERT_ENABLE |=>
    reg_rdata == $past(channel1_alert_enable))
    else $error("alert enable read mismatch");

  // Enabled condition raises the alert
  a_alert_enabled: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !soft_reset && (fault_now & channel1_alert_enable) != 8'h00 |=> alert_out)
    else $error("enabled fault gave no alert");

  // Masked conditions never raise the alert
  a_alert_masked: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !alert_out && (fault_now & channel1_alert_enable) == 8'h00 |=> !alert_out)
    else $error("alert raised by masked fault");

  // Resolution output mirrors the stored bit
  a_resolution: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> adc_eight_bit == adc_resolution_select[mcr_pkg::RES_EIGHT_BIT])
    else $error("resolution output mismatch");

  // Enable low freezes registers and outputs
  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !clk_en |=> $stable(secondary_control) && $stable(channel1_fault_log) &&
    $stable(alert_out) && $stable(reg_rdata))
    else $error("state changed while clock enable low");

endmodule

// [test/mcr_host.sv]
// Host model issuing single-byte register accesses and addressing events
`timescale 1ns/100ps
module mcr_host (
  // Clock
  input  wire logic       sys_clk,
  // Register strobes toward the bank
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // Device addressed by the master
  output logic            bus_addressed
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    bus_addressed = 1'b0;
  end
  // Write one byte; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Read one byte, taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // One-cycle addressing event
  task automatic addressed();
    @(negedge sys_clk);
    bus_addressed = 1'b1;
    @(negedge sys_clk);
    bus_addressed = 1'b0;
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the control, alert and fault register bank
`timescale 1ns/100ps
module testbench;
  logic                        sys_clk, resetn, clk_en, stuck_bus_timeout, in_shutdown;
  logic                        reg_wr, reg_rd, bus_addressed;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [mcr_pkg::MEAS_W-1:0]  val [4];
  logic [mcr_pkg::MEAS_W-1:0]  hi [4];
  logic [mcr_pkg::MEAS_W-1:0]  lo [4];
  logic                        alert_out, wake_request, peak_hold_reset, soft_reset;
  logic                        adc_eight_bit;
  int                          failures, n_checks;
  int                          cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Bank and host model
  mcr_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_addressed(bus_addressed), .stuck_bus_timeout(stuck_bus_timeout),
    .in_shutdown(in_shutdown), .supply1_power_product(val[0]), .power_max(hi[0]),
    .power_min(lo[0]), .shunt1_differential_voltage(val[1]), .shunt_max(hi[1]),
    .shunt_min(lo[1]), .supply1_rail_voltage(val[2]), .rail_max(hi[2]), .rail_min(lo[2]),
    .aux_input_one(val[3]), .aux_max(hi[3]), .aux_min(lo[3]), .alert_out(alert_out),
    .wake_request(wake_request), .peak_hold_reset(peak_hold_reset),
    .soft_reset(soft_reset), .adc_eight_bit(adc_eight_bit));
  mcr_host u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_addressed(bus_addressed));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    u_host.rd(a, rd_v);
    chk("register", e, rd_v);
  endtask
  // All measurements inside their window
  task automatic idle_meas();
    for (int g = 0; g < 4; g++) begin
      val[g] = 24'h000100;
      hi[g]  = 24'h000200;
      lo[g]  = 24'h000080;
    end
  endtask
  // Reserved bits, peak-hold pulse, resolution
  task automatic t_fields();
    u_host.wr(8'h01, 8'hf8);
    chk("peak_hold_reset", 8'h01, {7'h00, peak_hold_reset});
    chk("soft_reset", 8'h00, {7'h00, soft_reset});
    rdchk(8'h01, 8'hb8);
    u_host.wr(8'h04, 8'hff);
    rdchk(8'h04, 8'h80);
    chk("adc_eight_bit", 8'h01, {7'h00, adc_eight_bit});
    u_host.wr(8'h04, 8'h00);
    rdchk(8'h04, 8'h00);
    chk("adc_eight_bit", 8'h00, {7'h00, adc_eight_bit});
    u_host.wr(8'h01, 8'h00);
    u_host.wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h00);
  endtask
  // Every fault condition in turn, alert masking and release
  task automatic t_faults();
    int g;
    u_host.wr(8'h02, 8'h55);
    rdchk(8'h02, 8'h55);
    for (g = 0; g < 4; g++) val[g] = hi[g];
    repeat (3) @(negedge sys_clk);
    idle_meas();
    rdchk(8'h03, 8'h00);
    for (int i = 0; i < 8; i++) begin
      g = (7 - i) / 2;
      val[g] = (i % 2 == 1) ? hi[g] + 24'h000001 : lo[g] - 24'h000001;
      repeat (2) @(negedge sys_clk);
      idle_meas();
      repeat (2) @(negedge sys_clk);
      rdchk(8'h03, 8'h01 << i);
      rdchk(8'h03, 8'h01 << i);
      chk("alert_out", {7'h00, 1'(8'h55 >> i)}, {7'h00, alert_out});
      u_host.wr(8'h03, 8'h00);
      rdchk(8'h03, 8'h00);
      u_host.addressed();
      chk("alert_out", {7'h00, 1'(8'h55 >> i)}, {7'h00, alert_out});
      u_host.wr(8'h01, 8'h80);
      u_host.addressed();
      @(negedge sys_clk);
      chk("alert_out", 8'h00, {7'h00, alert_out});
      u_host.wr(8'h01, 8'h00);
    end
  endtask
  // Clear-on-read of the fault log
  task automatic t_clear_read();
    u_host.wr(8'h01, 8'h20);
    val[0] = hi[0] + 24'h000001;
    repeat (2) @(negedge sys_clk);
    idle_meas();
    rdchk(8'h03, 8'h80);
    rdchk(8'h03, 8'h00);
    u_host.wr(8'h01, 8'h00);
  endtask
  // Auto wake from shutdown on stuck-bus timeout
  task automatic t_wake();
    in_shutdown = 1'b1;
    stuck_bus_timeout = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("wake_request", 8'h00, {7'h00, wake_request});
    u_host.wr(8'h01, 8'h10);
    repeat (2) @(negedge sys_clk);
    chk("wake_request", 8'h01, {7'h00, wake_request});
    stuck_bus_timeout = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("wake_request", 8'h00, {7'h00, wake_request});
    in_shutdown = 1'b0;
  endtask
  // Software reset returns the four registers, alert_out and adc_eight_bit to zero
  task automatic t_soft();
    u_host.wr(8'h02, 8'hff);
    val[1] = lo[1] - 24'h000001;
    repeat (2) @(negedge sys_clk);
    idle_meas();
    chk("alert_out", 8'h01, {7'h00, alert_out});
    u_host.wr(8'h04, 8'h80);
    u_host.wr(8'h01, 8'h01);
    chk("soft_reset", 8'h01, {7'h00, soft_reset});
    @(negedge sys_clk);
    chk("soft_reset", 8'h00, {7'h00, soft_reset});
    chk("alert_out", 8'h00, {7'h00, alert_out});
    chk("adc_eight_bit", 8'h00, {7'h00, adc_eight_bit});
    for (int a = 1; a < 5; a++) rdchk(8'(a), 8'h00);
  endtask
  // Clock enable low ignores writes
  task automatic t_freeze();
    u_host.wr(8'h02, 8'h3c);
    clk_en = 1'b0;
    u_host.wr(8'h02, 8'hc3);
    u_host.wr(8'h04, 8'h80);
    clk_en = 1'b1;
    rdchk(8'h02, 8'h3c);
    chk("adc_eight_bit", 8'h00, {7'h00, adc_eight_bit});
  endtask
  // Reset in mid-run clears registers and outputs
  task automatic t_reset();
    u_host.wr(8'h04, 8'h80);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk("adc_eight_bit", 8'h00, {7'h00, adc_eight_bit});
    resetn = 1'b1;
    rdchk(8'h02, 8'h00);
    rdchk(8'h04, 8'h00);
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    stuck_bus_timeout = 1'b0;
    in_shutdown = 1'b0;
    idle_meas();
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    for (int a = 1; a < 5; a++) rdchk(8'(a), 8'h00);
    t_fields();
    t_faults();
    t_clear_read();
    t_wake();
    t_soft();
    t_freeze();
    t_reset();
    summarize();
  end
endmodule
